/* File: hdl/amd_consts.vh */
/*
 * amd_consts.vh: constants of the addressing-mode decoder.
 * assumes: included by bare name from hdl/amd_decode.v and from the verif assertion and test files.
 */
`ifndef AMD_CONSTS_VH
`define AMD_CONSTS_VH

// prefix bytes
`define AMD_ALT_INDEX_PREFIX 8'h90
`define AMD_ALT_INDIRECT_PREFIX 8'h91
`define AMD_INDIRECT_PREFIX 8'h92

// opcode layout: group in [7:4], read-modify-write flag in bit 3
`define AMD_GRP_HI 7
`define AMD_GRP_LO 4
`define AMD_RMW_BIT 3

// opcode groups (base mode before any prefix)
`define AMD_G_INH 4'h0
`define AMD_G_IMM 4'h1
`define AMD_G_SDIR 4'h2
`define AMD_G_LDIR 4'h3
`define AMD_G_IDX0 4'h4
`define AMD_G_SIDX 4'h5
`define AMD_G_LIDX 4'h6
`define AMD_G_REL 4'h7
`define AMD_G_BIT 4'h8
`define AMD_G_BITREL 4'h9

// final addressing modes, 17 of them
`define AMD_M_INH 5'h00
`define AMD_M_IMM 5'h01
`define AMD_M_SDIR 5'h02
`define AMD_M_LDIR 5'h03
`define AMD_M_IDX0 5'h04
`define AMD_M_SIDX 5'h05
`define AMD_M_LIDX 5'h06
`define AMD_M_SIND 5'h07
`define AMD_M_LIND 5'h08
`define AMD_M_SINDIDX 5'h09
`define AMD_M_LINDIDX 5'h0a
`define AMD_M_REL 5'h0b
`define AMD_M_RELIND 5'h0c
`define AMD_M_BIT 5'h0d
`define AMD_M_BITIND 5'h0e
`define AMD_M_BITREL 5'h0f
`define AMD_M_BITINDREL 5'h10

// page zero upper byte
`define AMD_PAGE0 8'h00

`endif

/* File: hdl/amd_decode.v */
/* amd_decode.v: addressing-mode decode and effective-address generation.
 * assumes: ordered valid/ready byte stream, data memory ack after any delay,
 * index registers and pc stable while an instruction is decoded. */
// Function
// - inherent decoded from opcode, no operand bytes
// - immediate uses next byte as operand
// - short direct uses one address byte
// - long direct fetches two-byte address word
// - indexed address is unsigned index plus offset
// - no-offset indexed uses index register alone
// - no-offset length plus one with second index
// - short indexed sum keeps carry, up to 1fe
// - long indexed adds index to offset word
// - indirect reads pointer first, then operand address
// - short indirect reads one-byte pointer
// - long indirect reads two-byte pointer
// - relative adds signed byte to next pc
// - short forms page zero, long forms full
// - read-modify-write refuses long forms and immediate
// - prefix 90 swaps first index for second
// - prefix 92 turns direct into indirect forms
// - prefix 91 gives indirect indexed by second
`include "amd_consts.vh"
`default_nettype none

module amd_decode (
  // clock and reset
  input wire ref_clk_in,
  input wire rst_in,
  // program byte stream
  input wire pb_valid_in,
  input wire [7:0] pb_data_in,
  output wire pb_ready_out,
  // core state
  input wire [15:0] pc_in,
  input wire [7:0] x_in,
  input wire [7:0] y_in,
  // data memory read port
  output wire dm_rd_out,
  output wire [15:0] dm_addr_out,
  input wire dm_ack_in,
  input wire [7:0] dm_data_in,
  // per-instruction decode info
  output wire info_out,
  output wire [1:0] op_bytes_out,
  output wire ptr_need_out,
  // decode result
  output wire done_out,
  output wire [4:0] mode_out,
  output wire [7:0] opcode_out,
  output wire use_y_out,
  output wire [1:0] len_extra_out,
  output wire illegal_out,
  output wire [15:0] ea_out,
  output wire [7:0] imm_out,
  output wire [15:0] target_out
);
  localparam [2:0] S_OP = 3'h0;
  localparam [2:0] S_FETCH = 3'h1;
  localparam [2:0] S_PTR = 3'h2;
  localparam [2:0] S_WAIT = 3'h3;
  localparam [2:0] S_DONE = 3'h4;
  reg [2:0] state_q, state_d;
  reg [7:0] prefix_q;
  reg [15:0] start_pc_q;
  reg [7:0] opcode_q;
  reg [4:0] mode_q;
  reg use_y_q, ptr_word_q, ptr_need_q, illegal_q, ptr_hi_q;
  reg [1:0] nb_q, cnt_q;
  reg [7:0] b1_q, b2_q;
  reg [15:0] ptr_q;
  reg ready_q, rd_q, info_q, done_q;
  reg [15:0] addr_q, ea_q, target_q;
  reg [7:0] imm_q;
  reg [1:0] len_q;
  // combinational decode of the byte in hand
  reg [4:0] dmode;
  reg dy, dptr, dword, dill;
  reg [1:0] dnb;
  wire [3:0] grp = pb_data_in[`AMD_GRP_HI:`AMD_GRP_LO];
  wire is_pfx = (pb_data_in == `AMD_ALT_INDEX_PREFIX) ||
                (pb_data_in == `AMD_ALT_INDIRECT_PREFIX) ||
                (pb_data_in == `AMD_INDIRECT_PREFIX);
  wire p90 = (prefix_q == `AMD_ALT_INDEX_PREFIX);
  wire p91 = (prefix_q == `AMD_ALT_INDIRECT_PREFIX);
  wire p92 = (prefix_q == `AMD_INDIRECT_PREFIX);
  wire take = pb_valid_in && ready_q;
  always @* begin
    dmode = `AMD_M_INH;
    dy = p90 || p91;
    dill = 1'b0;
    case (grp)
      `AMD_G_INH: dill = p91 || p92;
      `AMD_G_IMM: begin
        dmode = `AMD_M_IMM;
        dill = p91 || p92;
      end
      `AMD_G_SDIR: begin
        dmode = p92 ? `AMD_M_SIND : `AMD_M_SDIR;
        dill = p91;
      end
      `AMD_G_LDIR: begin
        dmode = p92 ? `AMD_M_LIND : `AMD_M_LDIR;
        dill = p91;
      end
      `AMD_G_IDX0: begin
        dmode = `AMD_M_IDX0;
        dill = p91 || p92;
      end
      `AMD_G_SIDX: dmode = (p91 || p92) ? `AMD_M_SINDIDX : `AMD_M_SIDX;
      `AMD_G_LIDX: dmode = (p91 || p92) ? `AMD_M_LINDIDX : `AMD_M_LIDX;
      `AMD_G_REL: dmode = p92 ? `AMD_M_RELIND : `AMD_M_REL;
      `AMD_G_BIT: dmode = p92 ? `AMD_M_BITIND : `AMD_M_BIT;
      `AMD_G_BITREL: dmode = p92 ? `AMD_M_BITINDREL : `AMD_M_BITREL;
      default: dill = 1'b1;
    endcase
    // no second index on branch and bit forms
    if ((grp >= `AMD_G_REL) && (grp <= `AMD_G_BITREL) && (p90 || p91))
      dill = 1'b1;
    if (pb_data_in[`AMD_RMW_BIT] && ((dmode == `AMD_M_LDIR) ||
        (dmode == `AMD_M_LIDX) || (dmode == `AMD_M_LIND) ||
        (dmode == `AMD_M_LINDIDX) || (dmode == `AMD_M_IMM)))
      dill = 1'b1;
    // short direct one byte, long direct two
    case (dmode)
      `AMD_M_INH, `AMD_M_IDX0: dnb = 2'd0;
      `AMD_M_LDIR, `AMD_M_LIDX, `AMD_M_BITREL,
      `AMD_M_BITINDREL: dnb = 2'd2;
      default: dnb = 2'd1;
    endcase
    // pointer read for every indirect form
    dptr = (dmode == `AMD_M_SIND) || (dmode == `AMD_M_LIND) ||
           (dmode == `AMD_M_SINDIDX) || (dmode == `AMD_M_LINDIDX) ||
           (dmode == `AMD_M_RELIND) || (dmode == `AMD_M_BITIND) ||
           (dmode == `AMD_M_BITINDREL);
    dword = (dmode == `AMD_M_LIND) || (dmode == `AMD_M_LINDIDX);
  end
  // address arithmetic for the finished instruction
  wire [7:0] idx = use_y_q ? y_in : x_in;
  wire [1:0] pfx_len = (prefix_q != 8'h00) ? 2'd1 : 2'd0;
  wire [15:0] next_pc = start_pc_q + {14'h0000, pfx_len} +
                        {14'h0000, nb_q} + 16'h0001;
  wire [15:0] pz_b1 = {`AMD_PAGE0, b1_q};
  wire [15:0] pz_ptr = {`AMD_PAGE0, ptr_q[7:0]};
  wire [15:0] wd_b12 = {b1_q, b2_q};
  wire [15:0] idx16 = {`AMD_PAGE0, idx};
  reg [15:0] ea_c, tgt_c;
  reg [7:0] disp;
  wire [7:0] ptr_lo = ((state_q == S_FETCH) && (cnt_q == 2'd0)) ?
                      pb_data_in : b1_q;
  always @* begin
    ea_c = 16'h0000;
    disp = b1_q;
    case (mode_q)
      `AMD_M_SDIR, `AMD_M_BIT, `AMD_M_BITREL: ea_c = pz_b1;
      `AMD_M_LDIR: ea_c = wd_b12;
      `AMD_M_IDX0: ea_c = idx16;
      `AMD_M_SIDX: ea_c = pz_b1 + idx16;
      // unsigned add of index and word offset
      `AMD_M_LIDX: ea_c = wd_b12 + idx16;
      `AMD_M_SIND, `AMD_M_BITIND, `AMD_M_BITINDREL: ea_c = pz_ptr;
      `AMD_M_LIND: ea_c = ptr_q;
      `AMD_M_SINDIDX: ea_c = pz_ptr + idx16;
      `AMD_M_LINDIDX: ea_c = ptr_q + idx16;
      `AMD_M_RELIND: disp = ptr_q[7:0];
      default: ea_c = 16'h0000;
    endcase
    if ((mode_q == `AMD_M_BITREL) || (mode_q == `AMD_M_BITINDREL))
      disp = b2_q;
    tgt_c = next_pc + {{8{disp[7]}}, disp};
  end
  always @* begin
    state_d = state_q;
    case (state_q)
      // a second prefix is taken as an opcode and sequenced as one
      S_OP: if (take && (!is_pfx || (prefix_q != 8'h00)))
        state_d = (dnb != 2'd0) ? S_FETCH : S_DONE;
      S_FETCH: if (take && (cnt_q == nb_q - 2'd1))
        state_d = ptr_need_q ? S_PTR : S_DONE;
      S_PTR: state_d = S_WAIT;
      S_WAIT: if (dm_ack_in)
        state_d = (ptr_word_q && ptr_hi_q) ? S_PTR : S_DONE;
      S_DONE: state_d = S_OP;
      default: state_d = S_OP;
    endcase
  end
  always @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_q <= S_OP;
      prefix_q <= 8'h00;
      start_pc_q <= 16'h0000;
      opcode_q <= 8'h00;
      mode_q <= `AMD_M_INH;
      use_y_q <= 1'b0;
      ptr_word_q <= 1'b0;
      ptr_need_q <= 1'b0;
      illegal_q <= 1'b0;
      ptr_hi_q <= 1'b0;
      nb_q <= 2'd0;
      cnt_q <= 2'd0;
      b1_q <= 8'h00;
      b2_q <= 8'h00;
      ptr_q <= 16'h0000;
      ready_q <= 1'b0;
      rd_q <= 1'b0;
      addr_q <= 16'h0000;
      info_q <= 1'b0;
      done_q <= 1'b0;
      ea_q <= 16'h0000;
      target_q <= 16'h0000;
      imm_q <= 8'h00;
      len_q <= 2'd0;
    end else begin
      state_q <= state_d;
      ready_q <= (state_d == S_OP) || (state_d == S_FETCH);
      info_q <= 1'b0;
      done_q <= 1'b0;
      rd_q <= (state_d == S_PTR);
      if ((state_q == S_OP) && take) begin
        // prefix latched, first byte marks start pc
        if (prefix_q == 8'h00)
          start_pc_q <= pc_in;
        if (is_pfx && (prefix_q == 8'h00)) begin
          prefix_q <= pb_data_in;
        end else begin
          opcode_q <= pb_data_in;
          mode_q <= dmode;
          use_y_q <= dy;
          nb_q <= dnb;
          ptr_need_q <= dptr;
          ptr_word_q <= dword;
          ptr_hi_q <= dword;
          illegal_q <= dill || is_pfx;
          cnt_q <= 2'd0;
          info_q <= 1'b1;
        end
      end
      if ((state_q == S_FETCH) && take) begin
        cnt_q <= cnt_q + 2'd1;
        if (cnt_q == 2'd0)
          b1_q <= pb_data_in;
        else
          b2_q <= pb_data_in;
      end
      // high byte first, pointer byte may arrive this edge
      if (state_d == S_PTR)
        addr_q <= (state_q == S_WAIT) ?
                  (pz_b1 + 16'h0001) : {`AMD_PAGE0, ptr_lo};
      if ((state_q == S_WAIT) && dm_ack_in) begin
        ptr_hi_q <= 1'b0;
        if (ptr_word_q && ptr_hi_q)
          ptr_q[15:8] <= dm_data_in;
        else if (ptr_word_q)
          ptr_q[7:0] <= dm_data_in;
        else
          ptr_q <= {`AMD_PAGE0, dm_data_in};
      end
      if (state_q == S_DONE) begin
        done_q <= 1'b1;
        ea_q <= ea_c;
        target_q <= tgt_c;
        imm_q <= (mode_q == `AMD_M_IMM) ? b1_q : 8'h00;
        len_q <= pfx_len + nb_q;
        prefix_q <= 8'h00;
      end
    end
  end
  assign pb_ready_out = ready_q;
  assign dm_rd_out = rd_q;
  assign dm_addr_out = addr_q;
  assign info_out = info_q;
  assign op_bytes_out = nb_q;
  assign ptr_need_out = ptr_need_q;
  assign done_out = done_q;
  assign mode_out = mode_q;
  assign opcode_out = opcode_q;
  assign use_y_out = use_y_q;
  assign len_extra_out = len_q;
  assign illegal_out = illegal_q;
  assign ea_out = ea_q;
  assign imm_out = imm_q;
  assign target_out = target_q;
endmodule // amd_decode
`default_nettype wire

/* File: verif/amd_decode_sva.sv */
/* amd_decode_sva.sv: port assertions for the addressing-mode decoder.
   assumes: bound to amd_decode; one clock, rst_in async high. */
`include "amd_consts.vh"
`default_nettype none
module amd_decode_sva (
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_in,
  // core state
  input wire logic [7:0] x_in,
  input wire logic [7:0] y_in,
  // handshakes
  input wire logic pb_ready_out,
  input wire logic dm_rd_out,
  // decode info and result
  input wire logic info_out,
  input wire logic [1:0] op_bytes_out,
  input wire logic ptr_need_out,
  input wire logic done_out,
  input wire logic [4:0] mode_out,
  input wire logic [7:0] opcode_out,
  input wire logic use_y_out,
  input wire logic [1:0] len_extra_out,
  input wire logic illegal_out,
  input wire logic [15:0] ea_out,
  input wire logic [7:0] imm_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);
  sequence s_none; info_out ##1 (op_bytes_out == 2'h0 && !ptr_need_out);
  endsequence
  sequence s_ptr; info_out ##1 ptr_need_out; endsequence
  sequence s_idx0; done_out && mode_out == `AMD_M_IDX0; endsequence
  AST_NONE_DONE: assert property (s_none |-> done_out)
    else $error("done late without operand bytes");
  AST_PTR_READ: assert property (s_ptr |-> ##[0:6] dm_rd_out)
    else $error("no pointer read");
  AST_RD_NEED: assert property (dm_rd_out |-> ptr_need_out)
    else $error("read without pointer need");
  AST_RD_PULSE: assert property (dm_rd_out |=> !dm_rd_out)
    else $error("read request too long");
  AST_RD_STALL: assert property (dm_rd_out |-> !pb_ready_out)
    else $error("bytes taken during pointer read");
  AST_INFO_PULSE: assert property (info_out |=> !info_out)
    else $error("info not once");
  AST_DONE_PULSE: assert property (done_out |=> !done_out)
    else $error("done not once");
  AST_IDX0_LEN: assert property (s_idx0 |->
    len_extra_out == {1'b0, use_y_out})
    else $error("no-offset length wrong");
  AST_IDX0_EA: assert property (s_idx0 |-> ea_out ==
    {8'h00, use_y_out ? $past(y_in) : $past(x_in)})
    else $error("no-offset address wrong");
  AST_IMM_ZERO: assert property (done_out && mode_out != `AMD_M_IMM
    |-> imm_out == 8'h00)
    else $error("immediate not cleared");
  AST_RMW_LONG: assert property (done_out &&
    opcode_out[`AMD_RMW_BIT] &&
    (mode_out == `AMD_M_LDIR || mode_out == `AMD_M_LIDX ||
    mode_out == `AMD_M_IMM) |-> illegal_out)
    else $error("long rmw accepted");
endmodule // amd_decode_sva
`default_nettype wire

/* File: verif/amd_dmem_model.sv */
/* amd_dmem_model.sv: data memory answering decoder pointer reads.
   assumes: single-pulse reads; a byte read is its low address xor a5. */
`default_nettype none
module amd_dmem_model (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // read port
  input wire logic rd_in,
  input wire logic [15:0] addr_in,
  input wire logic [3:0] dly_in,
  output logic ack_out,
  output logic [7:0] data_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic busy_q;
  logic [3:0] cnt_q;
  logic [15:0] addr_q;
  // idle data toggles so a stale byte never looks valid
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      busy_q <= 1'b0;
      ack_out <= 1'b0;
      data_out <= 8'h00;
    end else begin
      ack_out <= 1'b0;
      data_out <= ~data_out;
      if (rd_in) begin
        busy_q <= 1'b1;
        cnt_q <= dly_in;
        addr_q <= addr_in;
      end else if (busy_q && cnt_q == 4'h0) begin
        busy_q <= 1'b0;
        ack_out <= 1'b1;
        data_out <= addr_q[7:0] ^ 8'ha5;
      end else if (busy_q) begin
        cnt_q <= cnt_q - 4'h1;
      end
    end
  end
endmodule // amd_dmem_model
`default_nettype wire

/* File: verif/amd_decode_test.sv */
/* amd_decode_test.sv: self-checking bench for amd_decode.
   assumes: memory model answers reads; index and pc held per test. */
`include "amd_consts.vh"
`default_nettype none
module amd_decode_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk_in, rst_in, pb_valid_in, dm_ack_in, pb_ready_out;
  logic dm_rd_out, info_out, ptr_need_out, done_out, use_y_out;
  logic illegal_out;
  logic [7:0] pb_data_in, x_in, y_in, dm_data_in, opcode_out, imm_out;
  logic [15:0] pc_in, dm_addr_out, ea_out, target_out;
  logic [1:0] op_bytes_out, len_extra_out;
  logic [4:0] mode_out;
  logic [3:0] dly;
  int miscompares, checks;
  amd_decode dut_u (.ref_clk_in, .rst_in, .pb_valid_in, .pb_data_in,
    .pb_ready_out, .pc_in, .x_in, .y_in, .dm_rd_out, .dm_addr_out,
    .dm_ack_in, .dm_data_in, .info_out, .op_bytes_out, .ptr_need_out,
    .done_out, .mode_out, .opcode_out, .use_y_out, .len_extra_out,
    .illegal_out, .ea_out, .imm_out, .target_out);
  amd_dmem_model mem_u (.clk_in(ref_clk_in), .rst_in, .rd_in(dm_rd_out),
    .addr_in(dm_addr_out), .dly_in(dly), .ack_out(dm_ack_in),
    .data_out(dm_data_in));
  initial begin
    ref_clk_in = 1'b0;
    forever #12.5 ref_clk_in = ~ref_clk_in;
  end
  task automatic report_and_stop;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cm(input logic [4:0] e);
    chk({11'h0, mode_out}, {11'h0, e});
  endtask
  // byte held until taken at an edge with ready high
  task automatic put(input logic [7:0] b);
    pb_valid_in <= 1'b1;
    pb_data_in <= b;
    @(posedge ref_clk_in);
    while (pb_ready_out !== 1'b1) @(posedge ref_clk_in);
  endtask
  task automatic ins(input logic [7:0] p, input logic [7:0] op,
      input logic [7:0] b1, input logic [7:0] b2, input int n);
    int i;
    if (p != 8'h00) put(p);
    put(op);
    if (n > 0) put(b1);
    if (n > 1) put(b2);
    pb_valid_in <= 1'b0;
    pb_data_in <= ~pb_data_in;
    i = 0;
    while (done_out !== 1'b1 && i < 30) begin
      @(posedge ref_clk_in);
      i++;
    end
    if (i >= 30) chk({15'h0, done_out}, 16'h1);
  endtask
  task automatic t_basic;
    ins(8'h00, 8'h01, 8'h00, 8'h00, 0);
    cm(`AMD_M_INH);
    chk({14'h0, op_bytes_out}, 16'h0);
    ins(8'h00, 8'h10, 8'h55, 8'h00, 1);
    chk({8'h0, imm_out}, 16'h55);
    ins(8'h00, 8'h20, 8'h80, 8'h00, 1);
    chk(ea_out, 16'h0080);
    ins(8'h00, 8'h30, 8'h12, 8'h34, 2);
    chk(ea_out, 16'h1234);
    chk({14'h0, op_bytes_out}, 16'h2);
    chk({8'h0, opcode_out}, 16'h0030);
    $display("test basic end");
  endtask
  task automatic t_idx;
    x_in <= 8'hff;
    y_in <= 8'h81;
    ins(8'h00, 8'h40, 8'h00, 8'h00, 0);
    chk(ea_out, 16'h00ff);
    ins(8'h90, 8'h40, 8'h00, 8'h00, 0);
    chk({14'h0, len_extra_out}, 16'h1);
    chk(ea_out, 16'h0081);
    chk({15'h0, use_y_out}, 16'h1);
    ins(8'h00, 8'h50, 8'hff, 8'h00, 1);
    chk(ea_out, 16'h01fe);
    ins(8'h00, 8'h60, 8'h12, 8'h34, 2);
    chk(ea_out, 16'h1333);
    $display("test indexed end");
  endtask
  task automatic t_ind;
    ins(8'h92, 8'h20, 8'h40, 8'h00, 1);
    cm(`AMD_M_SIND);
    chk({15'h0, ptr_need_out}, 16'h1);
    chk(ea_out, 16'h00e5);
    dly <= 4'h3;
    ins(8'h92, 8'h30, 8'h40, 8'h00, 1);
    chk(ea_out, 16'he5e4);
    chk(dm_addr_out, 16'h0041);
    ins(8'h92, 8'h50, 8'h40, 8'h00, 1);
    chk(ea_out, 16'h01e4);
    ins(8'h91, 8'h50, 8'h40, 8'h00, 1);
    chk(ea_out, 16'h0166);
    ins(8'h92, 8'h80, 8'h10, 8'h00, 1);
    cm(`AMD_M_BITIND);
    $display("test indirect end");
  endtask
  task automatic t_rel;
    pc_in <= 16'h1000;
    ins(8'h00, 8'h70, 8'h80, 8'h00, 1);
    chk(target_out, 16'h0f82);
    ins(8'h00, 8'h70, 8'h7f, 8'h00, 1);
    chk(target_out, 16'h1081);
    $display("test relative end");
  endtask
  task automatic t_more;
    ins(8'h92, 8'h70, 8'h40, 8'h00, 1);
    cm(`AMD_M_RELIND);
    chk(target_out, 16'h0fe8);
    ins(8'h00, 8'h94, 8'h30, 8'h10, 2);
    chk(ea_out, 16'h0030);
    chk(target_out, 16'h1013);
    ins(8'h92, 8'h94, 8'h40, 8'hf0, 2);
    cm(`AMD_M_BITINDREL);
    chk(ea_out, 16'h00e5);
    chk(target_out, 16'h0ff4);
    ins(8'h92, 8'h60, 8'h40, 8'h00, 1);
    chk(ea_out, 16'he6e3);
    ins(8'h92, 8'h92, 8'h40, 8'h10, 2);
    chk({15'h0, illegal_out}, 16'h1);
    $display("test more modes end");
  endtask
  task automatic t_bad;
    ins(8'h00, 8'h38, 8'h12, 8'h34, 2);
    chk({15'h0, illegal_out}, 16'h1);
    ins(8'h00, 8'h28, 8'h10, 8'h00, 1);
    chk({15'h0, illegal_out}, 16'h0);
    ins(8'h91, 8'h20, 8'h10, 8'h00, 1);
    chk({15'h0, illegal_out}, 16'h1);
    $display("test refused end");
  endtask
  initial begin
    repeat (5000) @(posedge ref_clk_in);
    miscompares++;
    report_and_stop;
  end
  initial begin
    rst_in = 1'b1;
    pb_valid_in = 1'b0;
    pb_data_in = 8'h00;
    pc_in = 16'h0000;
    x_in = 8'h00;
    y_in = 8'h00;
    dly = 4'h0;
    repeat (8) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    @(posedge ref_clk_in);
    t_basic;
    t_idx;
    t_ind;
    t_rel;
    t_more;
    t_bad;
    report_and_stop;
  end
endmodule // amd_decode_test
bind amd_decode amd_decode_sva chk_u (.ref_clk_in, .rst_in, .x_in, .y_in,
  .pb_ready_out, .dm_rd_out, .info_out, .op_bytes_out, .ptr_need_out,
  .done_out, .mode_out, .opcode_out, .use_y_out, .len_extra_out,
  .illegal_out, .ea_out, .imm_out);
`default_nettype wire
